// ==== seil_pkg.sv ====
// constants and state type for the sensor event interrupt logic
// assumes one clock domain shared with the host register port and the sequencer
package seil_pkg;

  // register addresses
  localparam logic [7:0] ADDR_PIN_CFG = 8'h03;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_MODE1 = 8'h05;
  localparam logic [7:0] ADDR_MODE2 = 8'h06;
  localparam logic [7:0] ADDR_FLAGS = 8'h21;

  // writable bits; reserved bits read as zero
  localparam logic [7:0] PIN_CFG_USED = 8'h03;
  localparam logic [7:0] MASK_USED = 8'h3f;
  localparam logic [7:0] MODE1_USED = 8'hff;
  localparam logic [7:0] MODE2_USED = 8'h0f;
  localparam logic [7:0] FLAGS_USED = 8'h3f;
  localparam logic [7:0] REG_RESET = 8'h00;

  // pin configuration fields
  localparam int PIN_OE_BIT = 0;
  localparam int PIN_REL_BIT = 1;

  // flag and mask bit positions
  localparam int FLAG_LIGHT_EXIT = 0;
  localparam int FLAG_LIGHT_ENTER = 1;
  localparam int FLAG_PROX_BASE = 2;
  localparam int FLAG_CMD = 5;

  // mode field low bit positions
  localparam int PROX1_MODE_LO = 4;
  localparam int PROX2_MODE_LO = 6;
  localparam int PROX3_MODE_LO = 0;
  localparam int CMD_MODE_LO = 2;
  localparam int LIGHT_EXIT_BIT = 0;
  localparam int LIGHT_SRC_BIT = 1;
  localparam int LIGHT_ENTER_BIT = 2;
  localparam logic [2:0] LIGHT_MODE_EVERY = 3'h0;

  // proximity mode encodings
  localparam logic [1:0] PM_EVERY = 2'h0;
  localparam logic [1:0] PM_CROSS = 2'h1;
  localparam logic [1:0] PM_ABOVE = 2'h3;

  // response error marker
  localparam int RESP_ERR_BIT = 7;

  // compressed 8-bit format: exponent in high nibble, mantissa in low nibble
  localparam int CMP_EXP_LO = 4;
  localparam int NIBBLE_W = 4;
  localparam int SAMPLE_W = 16;
  localparam int PROX_CH = 3;

  typedef struct packed {
    logic [7:0] pin_cfg;
    logic [7:0] mask;
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic [PROX_CH-1:0] prox_above;
    logic [PROX_CH-1:0][7:0] prox_hist;
    logic [1:0] light_in;
    logic pin_out;
    logic pin_oe_n;
  } seil_state_t;

  localparam seil_state_t STATE_RESET = '{
    pin_cfg: REG_RESET, mask: REG_RESET, mode1: REG_RESET, mode2: REG_RESET,
    flags: REG_RESET, rdata: REG_RESET, prox_above: '0, prox_hist: '0,
    light_in: '0, pin_out: 1'b0, pin_oe_n: 1'b1};

endpackage

// ==== seil_core.sv ====
// event flags, masks, modes and the open-drain interrupt pin of the sensor
// assumes host register port and measurement sequencer run on clk, no sync needed
//
// Notes on behaviour
// - pin is driven only while the output-enable bit of pin configuration is set
// - pin asserts when any bit of mask AND flags is set
// - with release-select zero, pin holds until host clears the flags
// - writing flags clears each bit written one, bits written zero unchanged
// - sequencer sets flags only as mask and both mode registers select
// - proximity one masked never flags; mode zero flags after every sample
// - proximity one mode 01 flags on threshold crossing either direction
// - proximity one mode 11 flags on each sample above its threshold
// - proximity compares use shared hysteresis, history check, compressed thresholds
// - proximity two and three use same encoding, own thresholds
// - light flag zero on leaving region, flag one on entering, visible or infrared
// - command flag on every new response, or only on new error code
`timescale 1ns/1ps

module seil_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // proximity samples from the sequencer
  input wire logic [seil_pkg::PROX_CH-1:0] prox_sample_valid,
  input wire logic [seil_pkg::PROX_CH-1:0][seil_pkg::SAMPLE_W-1:0] prox_sample,
  input wire logic [7:0] prox1_threshold,
  input wire logic [7:0] prox2_threshold,
  input wire logic [7:0] prox3_threshold,
  input wire logic [7:0] prox_hysteresis,
  input wire logic [7:0] prox_history_check,
  // ambient light samples, index 0 visible, 1 infrared
  input wire logic [1:0] light_sample_valid,
  input wire logic [1:0][seil_pkg::SAMPLE_W-1:0] light_sample,
  input wire logic [7:0] light_low_threshold,
  input wire logic [7:0] light_high_threshold,
  // command responses
  input wire logic resp_valid,
  input wire logic [7:0] resp_value,
  // open-drain interrupt pin, active low on the wire
  output logic irq_pin_out,
  output logic irq_pin_oe_n,
  // flag register for observation
  output logic [7:0] event_flags
);

  seil_pkg::seil_state_t q;
  seil_pkg::seil_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // expand the 8-bit compressed format to a full sample width
  function automatic logic [seil_pkg::SAMPLE_W-1:0] expand(input logic [7:0] c);
    logic [31:0] m;
    logic [3:0] e;
    m = {28'h0000000, c[seil_pkg::NIBBLE_W-1:0]};
    e = c[seil_pkg::CMP_EXP_LO +: seil_pkg::NIBBLE_W];
    expand = seil_pkg::SAMPLE_W'(m << e);
  endfunction

  // read view of a register, reserved bits zero
  function automatic logic [7:0] reg_view(input logic [7:0] a,
                                          input seil_pkg::seil_state_t s);
    case (a)
      seil_pkg::ADDR_PIN_CFG: reg_view = s.pin_cfg;
      seil_pkg::ADDR_MASK: reg_view = s.mask;
      seil_pkg::ADDR_MODE1: reg_view = s.mode1;
      seil_pkg::ADDR_MODE2: reg_view = s.mode2;
      seil_pkg::ADDR_FLAGS: reg_view = s.flags;
      default: reg_view = 8'h00;
    endcase
  endfunction

  // mode field of a proximity channel
  function automatic logic [1:0] prox_mode(input int ch, input seil_pkg::seil_state_t s);
    case (ch)
      0: prox_mode = s.mode1[seil_pkg::PROX1_MODE_LO +: 2];
      1: prox_mode = s.mode1[seil_pkg::PROX2_MODE_LO +: 2];
      default: prox_mode = s.mode2[seil_pkg::PROX3_MODE_LO +: 2];
    endcase
  endfunction

  // history check passes when all selected history bits agree
  function automatic logic hist_agree(input logic [7:0] h, input logic [7:0] sel);
    hist_agree = ((h & sel) == sel) || ((h & sel) == 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [7:0] clr;
  logic [7:0] set;
  logic [seil_pkg::PROX_CH-1:0][7:0] th_c;
  logic [seil_pkg::SAMPLE_W:0] hyst;
  logic [seil_pkg::SAMPLE_W:0] th;
  logic [seil_pkg::SAMPLE_W:0] smp;
  logic [seil_pkg::SAMPLE_W-1:0] lo_th;
  logic [seil_pkg::SAMPLE_W-1:0] hi_th;
  logic cand;
  logic [7:0] hist;
  logic now_in;
  logic [1:0] pm;
  logic src;

  always_comb begin
    d = q;
    clr = 8'h00;
    set = 8'h00;
    th_c[0] = prox1_threshold;
    th_c[1] = prox2_threshold;
    th_c[2] = prox3_threshold;
    hyst = {1'b0, expand(prox_hysteresis)};
    th = '0;
    smp = '0;
    cand = 1'b0;
    hist = 8'h00;
    lo_th = expand(light_low_threshold);
    hi_th = expand(light_high_threshold);
    now_in = 1'b0;
    pm = 2'h0;
    src = q.mode1[seil_pkg::LIGHT_SRC_BIT];

    // host writes
    if (reg_wr) begin
      case (reg_addr)
        seil_pkg::ADDR_PIN_CFG: d.pin_cfg = reg_wdata & seil_pkg::PIN_CFG_USED;
        seil_pkg::ADDR_MASK: d.mask = reg_wdata & seil_pkg::MASK_USED;
        seil_pkg::ADDR_MODE1: d.mode1 = reg_wdata & seil_pkg::MODE1_USED;
        seil_pkg::ADDR_MODE2: d.mode2 = reg_wdata & seil_pkg::MODE2_USED;
        seil_pkg::ADDR_FLAGS: clr = reg_wdata;
        default: ;
      endcase
    end

    // host reads; release-select one makes a flag read self-clearing
    if (reg_rd) begin
      d.rdata = reg_view(reg_addr, q);
      if (reg_addr == seil_pkg::ADDR_FLAGS && q.pin_cfg[seil_pkg::PIN_REL_BIT]) begin
        clr = clr | q.flags;
      end
    end

    // proximity channels: hysteresis band around the threshold, then history
    for (int i = 0; i < seil_pkg::PROX_CH; i++) begin
      if (prox_sample_valid[i]) begin
        th = {1'b0, expand(th_c[i])};
        smp = {1'b0, prox_sample[i]};
        if (smp > th + hyst) begin
          cand = 1'b1;
        end else if (smp + hyst < th) begin
          cand = 1'b0;
        end else begin
          cand = q.prox_above[i];
        end
        hist = {q.prox_hist[i][6:0], cand};
        d.prox_hist[i] = hist;
        if (hist_agree(hist, prox_history_check)) begin
          d.prox_above[i] = cand;
        end
        pm = prox_mode(i, q);
        if (q.mask[seil_pkg::FLAG_PROX_BASE + i]) begin
          case (pm)
            seil_pkg::PM_EVERY: set[seil_pkg::FLAG_PROX_BASE + i] = 1'b1;
            seil_pkg::PM_CROSS:
              set[seil_pkg::FLAG_PROX_BASE + i] = d.prox_above[i] != q.prox_above[i];
            seil_pkg::PM_ABOVE: set[seil_pkg::FLAG_PROX_BASE + i] = d.prox_above[i];
            // invalid mode raises nothing
            default: ;
          endcase
        end
      end
    end

    // ambient light: region tracked per source so switching source is clean
    for (int j = 0; j < 2; j++) begin
      if (light_sample_valid[j]) begin
        now_in = (light_sample[j] > lo_th) && (light_sample[j] < hi_th);
        d.light_in[j] = now_in;
        if (q.mode1[2:0] == seil_pkg::LIGHT_MODE_EVERY) begin
          if (j == 0 && q.mask[seil_pkg::FLAG_LIGHT_EXIT]) begin
            set[seil_pkg::FLAG_LIGHT_EXIT] = 1'b1;
          end
        end else if (j == int'(src)) begin
          if (q.mask[seil_pkg::FLAG_LIGHT_EXIT] && q.mode1[seil_pkg::LIGHT_EXIT_BIT]
              && q.light_in[j] && !now_in) begin
            set[seil_pkg::FLAG_LIGHT_EXIT] = 1'b1;
          end
          if (q.mask[seil_pkg::FLAG_LIGHT_ENTER] && q.mode1[seil_pkg::LIGHT_ENTER_BIT]
              && !q.light_in[j] && now_in) begin
            set[seil_pkg::FLAG_LIGHT_ENTER] = 1'b1;
          end
        end
      end
    end

    if (resp_valid && q.mask[seil_pkg::FLAG_CMD]) begin
      if (!q.mode2[seil_pkg::CMD_MODE_LO] || resp_value[seil_pkg::RESP_ERR_BIT]) begin
        set[seil_pkg::FLAG_CMD] = 1'b1;
      end
    end

    // sticky flags, a set in the clearing cycle wins
    d.flags = ((q.flags & ~clr) | set) & seil_pkg::FLAGS_USED;

    d.pin_out = 1'b0;
    d.pin_oe_n = !(q.pin_cfg[seil_pkg::PIN_OE_BIT] && |(q.mask & q.flags));
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset loads even with ce low, otherwise ce low freezes everything

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= seil_pkg::STATE_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq_pin_out = q.pin_out;
  assign irq_pin_oe_n = q.pin_oe_n;
  assign event_flags = q.flags;

endmodule

// ==== seil_checker_assertions.sv ====
// checker: port-level properties of the interrupt logic
// assumes ce high while reset is held; shadows host writes
`timescale 1ns/1ps
module seil_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [seil_pkg::PROX_CH-1:0] prox_sample_valid,
  input wire logic [1:0] light_sample_valid,
  input wire logic resp_valid,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_n,
  input wire logic [7:0] event_flags
);
  logic [7:0] cfg_q, mask_q, mode1_q, mode2_q;
  logic fw, quiet;
  assign fw = ce && reg_wr && reg_addr == 8'h21;
  assign quiet = !(|prox_sample_valid) && !(|light_sample_valid) && !resp_valid && !reg_rd;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {cfg_q, mask_q, mode1_q, mode2_q} <= 32'h0;
    end else if (ce && reg_wr) begin
      if (reg_addr == 8'h03) cfg_q <= reg_wdata & seil_pkg::PIN_CFG_USED;
      if (reg_addr == 8'h04) mask_q <= reg_wdata & seil_pkg::MASK_USED;
      if (reg_addr == 8'h05) mode1_q <= reg_wdata;
      if (reg_addr == 8'h06) mode2_q <= reg_wdata & seil_pkg::MODE2_USED;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pin_out_zero: assert property (irq_pin_out == 1'b0)
    else $error("pin drive value not zero");
  a_pin_follows: assert property (ce |=> irq_pin_oe_n ==
    !($past(cfg_q[0]) && |($past(mask_q) & $past(event_flags))))
    else $error("pin level wrong");
  a_flags_w1c: assert property (fw && quiet |=>
    event_flags == ($past(event_flags) & ~$past(reg_wdata))) else $error("clear wrong");
  a_flags_sticky: assert property (ce && !fw && !(reg_rd && reg_addr == 8'h21) |=>
    (event_flags & $past(event_flags)) == $past(event_flags)) else $error("flag lost");
  a_mask_gates: assert property (ce |=>
    (event_flags & ~$past(event_flags) & ~$past(mask_q)) == 8'h00) else $error("masked set");
  a_prox_every: assert property (ce && prox_sample_valid[0] && mask_q[2]
    && mode1_q[5:4] == 2'h0 |=> event_flags[2]) else $error("sample flag missing");
  a_cmd_every: assert property (ce && resp_valid && mask_q[5] && !mode2_q[2]
    |=> event_flags[5]) else $error("command flag missing");
  a_mask_read: assert property (ce && reg_rd && reg_addr == 8'h04 |=>
    reg_rdata == $past(mask_q)) else $error("mask readback wrong");
endmodule
bind seil_core seil_checker chk (.clk, .rst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .prox_sample_valid, .light_sample_valid, .resp_valid, .irq_pin_out,
  .irq_pin_oe_n, .event_flags);

// ==== seil_host_model.sv ====
// host model: drives the register port of the interrupt logic
// assumes read data is valid one edge after the strobe
`timescale 1ns/1ps
module seil_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // released data lines must not look valid
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic service(output logic [7:0] seen);
    rd(8'h21, seen);
    wr(8'h21, seen);
  endtask
endmodule

// ==== test_sensor_event_interrupt_logic.sv ====
// testbench: host model plus sequencer strobes around the interrupt logic
// assumes the checker is bound to seil_core
`timescale 1ns/1ps
module test_sensor_event_interrupt_logic;
  logic clk, rst_n, ce, reg_wr, reg_rd, resp_valid, irq_pin_out, irq_pin_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, event_flags, resp_value, d;
  logic [7:0] prox1_threshold, prox2_threshold, prox3_threshold, prox_hysteresis;
  logic [7:0] prox_history_check, light_low_threshold, light_high_threshold;
  logic [2:0] prox_sample_valid;
  logic [2:0][15:0] prox_sample;
  logic [1:0] light_sample_valid;
  logic [1:0][15:0] light_sample;
  int errors, cmp_count;
  seil_core dut (.clk, .rst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .prox_sample_valid, .prox_sample, .prox1_threshold, .prox2_threshold, .prox3_threshold,
    .prox_hysteresis, .prox_history_check, .light_sample_valid, .light_sample,
    .light_low_threshold, .light_high_threshold, .resp_valid, .resp_value, .irq_pin_out,
    .irq_pin_oe_n, .event_flags);
  seil_host_model host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(input logic [2:0] p, input logic r);
    @(posedge clk);
    #1;
    {prox_sample_valid, resp_valid} = {p, r};
    @(posedge clk);
    #1;
    {prox_sample_valid, resp_valid} = 4'h0;
  endtask
  task automatic lpulse(input logic [1:0] l);
    @(posedge clk);
    #1;
    light_sample_valid = l;
    @(posedge clk);
    #1;
    light_sample_valid = 2'h0;
  endtask
  task automatic t_regs;
    host.rd(8'h04, d);
    chk("mask reset", 8'h00, d);
    host.wr(8'h04, 8'hff);
    host.rd(8'h04, d);
    chk("mask rsvd", 8'h3f, d);
    host.wr(8'h06, 8'hff);
    host.rd(8'h06, d);
    chk("mode2 rsvd", 8'h0f, d);
    host.rd(8'h10, d);
    chk("unmapped", 8'h00, d);
    host.wr(8'h04, 8'h00);
    host.wr(8'h06, 8'h00);
  endtask
  task automatic t_every;
    host.wr(8'h03, 8'h01);
    host.wr(8'h04, 8'h04);
    pulse(3'h1, 1'b0);
    chk("flags", 8'h04, event_flags);
    @(posedge clk);
    #1;
    chk("pin", 8'h00, {7'h0, irq_pin_oe_n});
    chk("pin drive", 8'h00, {7'h0, irq_pin_out});
    host.service(d);
    chk("copy", 8'h04, d);
    @(posedge clk);
    #1;
    chk("pin off", 8'h01, {7'h0, irq_pin_oe_n});
    host.wr(8'h03, 8'h00);
    // all three sampled, only the first unmasked, pin disabled with a live flag
    pulse(3'h7, 1'b0);
    chk("masked", 8'h04, event_flags);
    @(posedge clk);
    #1;
    chk("pin dis", 8'h01, {7'h0, irq_pin_oe_n});
    host.service(d);
    chk("cleared", 8'h00, event_flags);
  endtask
  task automatic t_thresh(input logic [15:0] s, input logic [7:0] e);
    prox_sample = {3{s}};
    pulse(3'h7, 1'b0);
    chk("prox", e, event_flags);
    host.service(d);
  endtask
  task automatic t_prox;
    // ch1 and ch2 above-threshold, ch3 crossing
    host.wr(8'h04, 8'h1c);
    host.wr(8'h05, 8'hf0);
    host.wr(8'h06, 8'h01);
    t_thresh(16'd100, 8'h1c);
    t_thresh(16'd5, 8'h10);
    t_thresh(16'd5, 8'h00);
    prox_hysteresis = 8'h02;
    t_thresh(16'd11, 8'h00);
    t_thresh(16'd13, 8'h1c);
  endtask
  task automatic t_history;
    host.wr(8'h04, 8'h04);
    host.wr(8'h05, 8'h10);
    prox_history_check = 8'h03;
    prox_sample = {3{16'd5}};
    // first low sample disagrees with the high one before it, so no crossing yet
    pulse(3'h1, 1'b0);
    chk("hist hold", 8'h00, event_flags);
    pulse(3'h1, 1'b0);
    chk("hist cross", 8'h04, event_flags);
    host.service(d);
    prox_history_check = 8'h00;
    host.wr(8'h05, 8'h20);
    pulse(3'h1, 1'b0);
    chk("mode 10", 8'h00, event_flags);
  endtask
  task automatic t_cmd;
    host.wr(8'h04, 8'h20);
    host.wr(8'h06, 8'h04);
    resp_value = 8'h01;
    pulse(3'h0, 1'b1);
    chk("no err", 8'h00, event_flags);
    resp_value = 8'h80;
    pulse(3'h0, 1'b1);
    chk("err", 8'h20, event_flags);
    host.service(d);
    host.wr(8'h06, 8'h00);
    resp_value = 8'h01;
    pulse(3'h0, 1'b1);
    chk("resp", 8'h20, event_flags);
    host.service(d);
  endtask
  task automatic t_light;
    light_low_threshold = 8'h05;
    light_high_threshold = 8'h0f;
    light_sample = {16'd10, 16'd10};
    host.wr(8'h04, 8'h03);
    host.wr(8'h05, 8'h05);
    // infrared is not the monitored source here
    lpulse(2'h2);
    chk("ir ignored", 8'h00, event_flags);
    lpulse(2'h1);
    chk("enter", 8'h02, event_flags);
    light_sample = {16'd10, 16'd20};
    lpulse(2'h1);
    chk("exit", 8'h03, event_flags);
    host.service(d);
    host.wr(8'h04, 8'h01);
    host.wr(8'h05, 8'h00);
    lpulse(2'h2);
    chk("ir every", 8'h00, event_flags);
    lpulse(2'h1);
    chk("vis every", 8'h01, event_flags);
    host.service(d);
  endtask
  task automatic t_release;
    host.wr(8'h04, 8'h04);
    host.wr(8'h03, 8'h01);
    pulse(3'h1, 1'b0);
    host.rd(8'h21, d);
    chk("read keeps", 8'h04, event_flags);
    chk("pin held", 8'h00, {7'h0, irq_pin_oe_n});
    host.wr(8'h03, 8'h03);
    host.rd(8'h21, d);
    chk("read copy", 8'h04, d);
    chk("read clear", 8'h00, event_flags);
    host.wr(8'h03, 8'h01);
  endtask
  task automatic t_collide;
    // clear and set taken at the same edge
    fork
      host.wr(8'h21, 8'h04);
      pulse(3'h1, 1'b0);
    join
    chk("set wins", 8'h04, event_flags);
    host.service(d);
  endtask
  task automatic t_freeze;
    ce = 1'b0;
    pulse(3'h1, 1'b0);
    chk("frozen", 8'h00, event_flags);
    ce = 1'b1;
    pulse(3'h1, 1'b0);
    chk("thawed", 8'h04, event_flags);
    host.service(d);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {rst_n, prox_sample_valid, prox_sample, resp_valid, resp_value} = '0;
    {prox_hysteresis, prox_history_check, light_sample_valid, light_sample} = '0;
    {light_low_threshold, light_high_threshold} = '0;
    {prox1_threshold, prox2_threshold, prox3_threshold} = {3{8'h0a}};
    ce = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_every();
    t_prox();
    t_history();
    t_cmd();
    t_light();
    t_release();
    t_collide();
    t_freeze();
    tally_and_finish();
  end
endmodule
